// file: core/tccp_pkg.sv
// tccp_pkg: register map, field positions, reset values and mode decoding
package tccp_pkg;

  // ==========================================================
  // register byte addresses
  localparam logic [7:0] OFF_MAIN = 8'h00;
  localparam logic [7:0] OFF_CNT_HI = 8'h04;
  localparam logic [7:0] OFF_CNT_LO = 8'h08;
  localparam logic [7:0] OFF_LIM_HI = 8'h0C;
  localparam logic [7:0] OFF_LIM_LO = 8'h10;
  localparam logic [7:0] OFF_CH0_CTL = 8'h14;
  localparam logic [7:0] OFF_CH0_HI = 8'h18;
  localparam logic [7:0] OFF_CH0_LO = 8'h1C;
  localparam logic [7:0] OFF_CH1_CTL = 8'h20;
  localparam logic [7:0] OFF_CH1_HI = 8'h24;
  localparam logic [7:0] OFF_CH1_LO = 8'h28;

  // ==========================================================
  // main_timer_control fields
  localparam int MC_OVF = 7;
  localparam int MC_OVIE = 6;
  localparam int MC_HALT = 5;
  localparam int MC_CLR = 4;
  localparam int MC_DIV_LSB = 0;

  // ==========================================================
  // channel control fields
  localparam int CC_FLAG = 7;
  localparam int CC_IE = 6;
  localparam int CC_LINK = 5;
  localparam int CC_SEL = 4;
  localparam int CC_ELH = 3;
  localparam int CC_ELL = 2;
  localparam int CC_TOW = 1;
  localparam int CC_MAX = 0;

  // ==========================================================
  // reset values and sizes
  localparam logic HALT_RST = 1'b1;
  localparam logic PIN_RST = 1'b1;
  localparam logic [2:0] DIV_SEL_RST = 3'h0;
  localparam logic [15:0] LIM_RST = 16'hFFFF;
  localparam int DIV_W = 6;

  // ==========================================================
  // edge/level codes
  localparam logic [1:0] EL_NONE = 2'h0;
  localparam logic [1:0] EL_TOG = 2'h1;
  localparam logic [1:0] EL_CLR = 2'h2;
  localparam logic [1:0] EL_SET = 2'h3;

  typedef enum logic [1:0] {
    MD_PRESET,
    MD_CAPTURE,
    MD_COMPARE,
    MD_BUFFER
  } tccp_mode_t;

  function automatic tccp_mode_t tccp_mode(input logic link,
                                           input logic sel,
                                           input logic [1:0] el);
    if (link && el != EL_NONE) begin
      return MD_BUFFER;
    end else if (sel) begin
      return MD_COMPARE;
    end else if (el != EL_NONE) begin
      return MD_CAPTURE;
    end else begin
      return MD_PRESET;
    end
  endfunction

endpackage

// file: core/tccp_ch_if.sv
// tccp_ch_if: signals between the timer core and one channel
interface tccp_ch_if;
  import tccp_pkg::*;
  logic upd;
  logic wrap;
  logic halt;
  logic en;
  logic link;
  logic sel;
  logic [1:0] el;
  logic tov;
  logic maxf;
  logic [15:0] cnt;
  logic [15:0] cmp_val;
  logic cmp_blk;
  logic cap_blk;
  logic evt;
  logic pin_o;
  logic pin_oe;

  modport core (
    output upd, wrap, halt, en, link, sel, el, tov, maxf, cnt, cmp_val,
    output cmp_blk, cap_blk,
    input evt, pin_o, pin_oe
  );
  modport chan (
    input upd, wrap, halt, en, link, sel, el, tov, maxf, cnt, cmp_val,
    input cmp_blk, cap_blk,
    output evt, pin_o, pin_oe
  );
endinterface

// file: core/tccp_chan.sv
// tccp_chan: one capture/compare channel with its pin logic
module tccp_chan
  import tccp_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // pin input
  input wire logic pin_i,
  // core side
  tccp_ch_if.chan ch
);

  typedef struct packed {
    logic [2:0] sync;
    logic lvl;
    logic pin;
    logic oe;
    logic maxe;
  } tccp_chst_t;

  localparam tccp_chst_t CH_RST = '{pin: PIN_RST, default: '0};

  tccp_chst_t st_reg;
  tccp_chst_t st_next;
  tccp_mode_t mode;
  logic cmp;
  logic edge_hit;
  logic cap;
  logic match;

  // ==========================================================
  // event detection
  assign mode = tccp_mode(ch.link, ch.sel, ch.el);
  assign cmp = (mode == MD_COMPARE) || (mode == MD_BUFFER);
  // a change counts only once the last two sync stages agree
  assign edge_hit = (st_reg.sync[1] == st_reg.sync[2])
                 && (st_reg.sync[2] != st_reg.lvl)
                 && (st_reg.sync[2] ? ch.el[0] : ch.el[1]);
  assign cap = ch.en && (mode == MD_CAPTURE) && edge_hit
            && !ch.halt && !ch.cap_blk;
  assign match = ch.en && cmp && ch.upd && (ch.cnt == ch.cmp_val)
              && !ch.cmp_blk;
  assign ch.evt = cap || match;
  assign ch.pin_o = st_reg.pin;
  assign ch.pin_oe = st_reg.oe;

  // ==========================================================
  // pin state
  always_comb begin
    st_next = st_reg;
    st_next.sync = {st_reg.sync[1:0], pin_i};
    if (st_reg.sync[1] == st_reg.sync[2]) begin
      st_next.lvl = st_reg.sync[2];
    end
    // full duty is sampled per period, so it acts from the next one
    if (ch.wrap) begin
      st_next.maxe = ch.maxf;
    end
    st_next.oe = ch.en && (ch.el != EL_NONE) && cmp;
    if (ch.el == EL_NONE) begin
      st_next.pin = !ch.sel;
    end else if (cmp) begin
      if (ch.wrap && ch.tov) begin
        // a full-duty period holds its level instead of toggling
        if (st_reg.maxe && ch.el == EL_CLR) begin
          st_next.pin = 1'b1;
        end else if (st_reg.maxe && ch.el == EL_SET) begin
          st_next.pin = 1'b0;
        end else if (!st_reg.maxe) begin
          st_next.pin = !st_reg.pin;
        end
      end else if (match && !(ch.tov && st_reg.maxe)) begin
        case (ch.el)
          EL_TOG: st_next.pin = !st_reg.pin;
          EL_CLR: st_next.pin = 1'b0;
          EL_SET: st_next.pin = 1'b1;
          default: st_next.pin = st_reg.pin;
        endcase
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      st_reg <= CH_RST;
    end else begin
      st_reg <= st_next;
    end
  end

endmodule

// file: core/tccp_top.sv
// tccp_top: 16-bit timer with two capture/compare/pwm channels, apb slave
//
// Added by the designer: the register offsets and the APB interface to the registers.
module tccp_top
  import tccp_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // apb slave
  input wire logic [ADDR_W-1:0] paddr_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // channel pins
  input wire logic [1:0] ch_pin_i,
  output logic [1:0] ch_pin_o,
  output logic [1:0] ch_pin_oe_o,
  // interrupt requests
  output logic ovf_irq_o,
  output logic [1:0] ch_irq_o
);

  // ==========================================================
  // elaboration check
  if (ADDR_W < 8) begin : g_bad_addr
    $error("tccp_top: ADDR_W must be at least 8");
  end

  typedef enum logic [3:0] {
    SEL_NONE,
    SEL_MAIN,
    SEL_CNT_HI,
    SEL_CNT_LO,
    SEL_LIM_HI,
    SEL_LIM_LO,
    SEL_CH_CTL,
    SEL_CH_HI,
    SEL_CH_LO
  } tccp_sel_t;

  typedef struct packed {
    logic rdy;
    logic err;
    logic [7:0] rdata;
    logic ovf;
    logic ovf_arm;
    logic ovie;
    logic halt;
    logic [2:0] div_sel;
    logic [DIV_W-1:0] div;
    logic [15:0] cnt;
    logic [7:0] cnt_lat;
    logic lat_v;
    logic upd;
    logic wrap;
    logic [15:0] lim;
    logic lim_inh;
    logic [1:0] flag;
    logic [1:0] arm;
    logic [1:0] ie;
    logic link;
    logic [1:0] sel;
    logic [1:0][1:0] el;
    logic [1:0] tov;
    logic [1:0] maxf;
    logic [1:0][15:0] val;
    logic [1:0] cap_blk;
    logic [1:0] cmp_blk;
    logic buf_sel;
    logic buf_pend;
    logic irq_ovf;
    logic [1:0] irq_ch;
  } tccp_state_t;

  localparam tccp_state_t ST_RST = '{
    halt: HALT_RST,
    div_sel: DIV_SEL_RST,
    lim: LIM_RST,
    default: '0
  };

  // ==========================================================
  // address decoding
  function automatic tccp_sel_t dec_sel(input logic [ADDR_W-1:0] a);
    logic [7:0] o;
    o = a[7:0];
    if ((a >> 8) != '0) begin
      return SEL_NONE;
    end else if (o == OFF_MAIN) begin
      return SEL_MAIN;
    end else if (o == OFF_CNT_HI) begin
      return SEL_CNT_HI;
    end else if (o == OFF_CNT_LO) begin
      return SEL_CNT_LO;
    end else if (o == OFF_LIM_HI) begin
      return SEL_LIM_HI;
    end else if (o == OFF_LIM_LO) begin
      return SEL_LIM_LO;
    end else if (o == OFF_CH0_CTL || o == OFF_CH1_CTL) begin
      return SEL_CH_CTL;
    end else if (o == OFF_CH0_HI || o == OFF_CH1_HI) begin
      return SEL_CH_HI;
    end else if (o == OFF_CH0_LO || o == OFF_CH1_LO) begin
      return SEL_CH_LO;
    end else begin
      return SEL_NONE;
    end
  endfunction

  function automatic logic dec_ch(input logic [ADDR_W-1:0] a);
    logic [7:0] o;
    o = a[7:0];
    if (o == OFF_CH1_CTL || o == OFF_CH1_HI || o == OFF_CH1_LO) begin
      return 1'b1;
    end else begin
      return 1'b0;
    end
  endfunction

  // divider mask: select 7 is treated like 6
  function automatic logic [DIV_W-1:0] div_mask(input logic [2:0] s);
    if (s > 3'h6) begin
      return '1;
    end else begin
      return DIV_W'((1 << s) - 1);
    end
  endfunction

  tccp_state_t st_reg;
  tccp_state_t st_next;
  tccp_mode_t [1:0] mode;
  logic [1:0] evt;
  logic [1:0] pin_o;
  logic [1:0] pin_oe;
  logic acc;
  logic rd_cap;
  logic wr;
  logic ovf_set;
  logic tick;
  tccp_sel_t rsel;
  logic rch;
  logic [7:0] wd;

  assign acc = psel_i && penable_i;
  assign rd_cap = acc && !st_reg.rdy && !pwrite_i;
  assign wr = acc && st_reg.rdy && pwrite_i && pstrb_i[0];
  assign rsel = dec_sel(paddr_i);
  assign rch = dec_ch(paddr_i);
  assign wd = pwdata_i[7:0];
  assign tick = (st_reg.div & div_mask(st_reg.div_sel))
             == div_mask(st_reg.div_sel);
  assign ovf_set = st_reg.wrap && !st_reg.lim_inh;

  // ==========================================================
  // channels
  for (genvar g = 0; g < 2; g++) begin : g_ch
    tccp_ch_if chif ();
    assign mode[g] = tccp_mode((g == 0) && st_reg.link, st_reg.sel[g],
                               st_reg.el[g]);
    assign chif.upd = st_reg.upd;
    assign chif.wrap = st_reg.wrap;
    assign chif.halt = st_reg.halt;
    assign chif.en = (g == 0) || !st_reg.link;
    assign chif.link = (g == 0) && st_reg.link;
    assign chif.sel = st_reg.sel[g];
    assign chif.el = st_reg.el[g];
    assign chif.tov = st_reg.tov[g];
    assign chif.maxf = st_reg.maxf[g];
    assign chif.cnt = st_reg.cnt;
    // linked pair: channel 0 compares against the register last loaded before the latest wrap
    assign chif.cmp_val = ((g == 0) && st_reg.link && st_reg.buf_sel)
                        ? st_reg.val[1] : st_reg.val[g];
    assign chif.cmp_blk = st_reg.cmp_blk[g]
                        || ((g == 0) && st_reg.link && st_reg.cmp_blk[1]);
    assign chif.cap_blk = st_reg.cap_blk[g];
    assign evt[g] = chif.evt;
    assign pin_o[g] = chif.pin_o;
    assign pin_oe[g] = chif.pin_oe;
    tccp_chan u_chan (
      .clk_i(clk_i),
      .reset_n_i(reset_n_i),
      .pin_i(ch_pin_i[g]),
      .ch(chif)
    );
  end

  // ==========================================================
  // next state
  always_comb begin
    st_next = st_reg;
    st_next.upd = 1'b0;
    st_next.wrap = 1'b0;

    // prescaler and counter
    if (!st_reg.halt) begin
      st_next.div = st_reg.div + 1'b1;
      if (tick) begin
        st_next.upd = 1'b1;
        if (st_reg.cnt == st_reg.lim) begin
          st_next.cnt = '0;
          st_next.wrap = 1'b1;
        end else begin
          st_next.cnt = st_reg.cnt + 16'h0001;
        end
      end
    end
    if (ovf_set) begin
      st_next.ovf = 1'b1;
      st_next.ovf_arm = 1'b0;
    end
    if (st_reg.wrap) begin
      st_next.buf_sel = st_reg.buf_pend;
    end

    // channel events
    for (int i = 0; i < 2; i++) begin
      if (evt[i]) begin
        st_next.flag[i] = 1'b1;
        st_next.arm[i] = 1'b0;
        if (mode[i] == MD_CAPTURE) begin
          st_next.val[i] = st_reg.cnt;
        end
      end
    end

    // apb: one wait state, read effects at the wait-state edge, one edge before the data is taken
    st_next.rdy = acc && !st_reg.rdy;
    if (acc && !st_reg.rdy) begin
      st_next.rdata = 8'h00;
      st_next.err = (rsel == SEL_NONE);
    end
    if (rd_cap) begin
      case (rsel)
        SEL_MAIN: begin
          st_next.rdata = {st_reg.ovf, st_reg.ovie, st_reg.halt, 2'b00,
                           st_reg.div_sel};
          if (st_reg.ovf && !ovf_set) begin
            st_next.ovf_arm = 1'b1;
          end
        end
        SEL_CNT_HI: begin
          st_next.rdata = st_reg.cnt[15:8];
          if (!st_reg.lat_v) begin
            st_next.cnt_lat = st_reg.cnt[7:0];
            st_next.lat_v = 1'b1;
          end
        end
        SEL_CNT_LO: begin
          st_next.rdata = st_reg.lat_v ? st_reg.cnt_lat : st_reg.cnt[7:0];
          st_next.lat_v = 1'b0;
        end
        SEL_LIM_HI: st_next.rdata = st_reg.lim[15:8];
        SEL_LIM_LO: st_next.rdata = st_reg.lim[7:0];
        SEL_CH_CTL: begin
          st_next.rdata = {st_reg.flag[rch], st_reg.ie[rch],
                           st_reg.link && !rch, st_reg.sel[rch],
                           st_reg.el[rch], st_reg.tov[rch],
                           st_reg.maxf[rch]};
          if (st_reg.flag[rch] && !evt[rch]) begin
            st_next.arm[rch] = 1'b1;
          end
        end
        SEL_CH_HI: begin
          st_next.rdata = st_reg.val[rch][15:8];
          if (mode[rch] == MD_CAPTURE) begin
            st_next.cap_blk[rch] = 1'b1;
          end
        end
        SEL_CH_LO: begin
          st_next.rdata = st_reg.val[rch][7:0];
          st_next.cap_blk[rch] = 1'b0;
        end
        default: st_next.rdata = 8'h00;
      endcase
    end

    // apb writes take effect at the completing edge
    if (wr) begin
      case (rsel)
        SEL_MAIN: begin
          st_next.ovie = wd[MC_OVIE];
          st_next.halt = wd[MC_HALT];
          st_next.div_sel = wd[MC_DIV_LSB +: 3];
          if (!wd[MC_OVF] && st_reg.ovf_arm && !ovf_set) begin
            st_next.ovf = 1'b0;
          end
          st_next.ovf_arm = 1'b0;
          if (wd[MC_CLR]) begin
            st_next.cnt = '0;
            st_next.div = '0;
            st_next.lat_v = 1'b0;
            st_next.upd = 1'b0;
            st_next.wrap = 1'b0;
          end
        end
        SEL_LIM_HI: begin
          st_next.lim[15:8] = wd;
          st_next.lim_inh = 1'b1;
        end
        SEL_LIM_LO: begin
          st_next.lim[7:0] = wd;
          st_next.lim_inh = 1'b0;
        end
        SEL_CH_CTL: begin
          if (!(rch && st_reg.link)) begin
            st_next.ie[rch] = wd[CC_IE];
            st_next.sel[rch] = wd[CC_SEL];
            st_next.el[rch] = {wd[CC_ELH], wd[CC_ELL]};
            st_next.tov[rch] = wd[CC_TOW];
            st_next.maxf[rch] = wd[CC_MAX];
            if (!rch) begin
              st_next.link = wd[CC_LINK];
            end
            if (!wd[CC_FLAG] && st_reg.arm[rch] && !evt[rch]) begin
              st_next.flag[rch] = 1'b0;
            end
            st_next.arm[rch] = 1'b0;
          end
        end
        SEL_CH_HI: begin
          st_next.val[rch][15:8] = wd;
          if (st_reg.sel[rch] || st_reg.link) begin
            st_next.cmp_blk[rch] = 1'b1;
          end
          st_next.buf_pend = rch;
        end
        SEL_CH_LO: begin
          st_next.val[rch][7:0] = wd;
          st_next.cmp_blk[rch] = 1'b0;
          st_next.buf_pend = rch;
        end
        default: st_next.err = st_reg.err;
      endcase
    end

    // interrupt requests follow flag and enable
    st_next.irq_ovf = st_next.ovf && st_next.ovie;
    st_next.irq_ch = st_next.flag & st_next.ie;
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      st_reg <= ST_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  // ==========================================================
  // outputs
  assign prdata_o = {24'h000000, st_reg.rdata};
  assign pready_o = st_reg.rdy;
  assign pslverr_o = st_reg.err;
  assign ch_pin_o = pin_o;
  assign ch_pin_oe_o = pin_oe;
  assign ovf_irq_o = st_reg.irq_ovf;
  assign ch_irq_o = st_reg.irq_ch;

endmodule

// file: dv/tccp_monitor.sv
// tccp_monitor: port-level assertions for the timer block
module tccp_monitor
  import tccp_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // apb
  input wire logic [ADDR_W-1:0] paddr_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  // pins and requests
  input wire logic [1:0] ch_pin_i,
  input wire logic [1:0] ch_pin_o,
  input wire logic [1:0] ch_pin_oe_o,
  input wire logic ovf_irq_o,
  input wire logic [1:0] ch_irq_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========
  // write history: requests only drop and pin modes only change after a write lands
  logic wr_done;
  logic [2:0] wr_hist_reg;
  assign wr_done = psel_i & penable_i & pwrite_i & pready_o;
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      wr_hist_reg <= 3'h0;
    end else begin
      wr_hist_reg <= {wr_hist_reg[1:0], wr_done};
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  // ==========
  // properties
  property p_wait;
    psel_i && penable_i && !pready_o |=> pready_o;
  endproperty
  a_wait: assert property (p_wait)
    else $error("answer missing after wait state");
  property p_pulse;
    pready_o |=> !pready_o;
  endproperty
  a_pulse: assert property (p_pulse)
    else $error("ready held too long");
  property p_err;
    pready_o && paddr_i > OFF_CH1_LO |-> pslverr_o;
  endproperty
  a_err: assert property (p_err)
    else $error("unmapped access not refused");
  property p_hi;
    pready_o |-> prdata_o[31:8] == 24'h000000;
  endproperty
  a_hi: assert property (p_hi)
    else $error("read data above byte not zero");
  property p_irq0;
    $fell(ch_irq_o[0]) |-> wr_hist_reg != 3'h0;
  endproperty
  a_irq0: assert property (p_irq0)
    else $error("channel 0 request dropped without a write");
  property p_irq1;
    $fell(ch_irq_o[1]) |-> wr_hist_reg != 3'h0;
  endproperty
  a_irq1: assert property (p_irq1)
    else $error("channel 1 request dropped without a write");
  property p_ovf;
    $fell(ovf_irq_o) |-> wr_hist_reg != 3'h0;
  endproperty
  a_ovf: assert property (p_ovf)
    else $error("overflow request dropped without a write");
  property p_oe;
    $changed(ch_pin_oe_o) |-> wr_hist_reg != 3'h0;
  endproperty
  a_oe: assert property (p_oe)
    else $error("pin ownership changed without a write");
endmodule
bind tccp_top tccp_monitor #(.ADDR_W(ADDR_W)) mon_u (
  .clk_i(clk_i),
  .reset_n_i(reset_n_i),
  .paddr_i(paddr_i),
  .psel_i(psel_i),
  .penable_i(penable_i),
  .pwrite_i(pwrite_i),
  .pwdata_i(pwdata_i),
  .pstrb_i(pstrb_i),
  .prdata_o(prdata_o),
  .pready_o(pready_o),
  .pslverr_o(pslverr_o),
  .ch_pin_i(ch_pin_i),
  .ch_pin_o(ch_pin_o),
  .ch_pin_oe_o(ch_pin_oe_o),
  .ovf_irq_o(ovf_irq_o),
  .ch_irq_o(ch_irq_o)
);

// file: dv/tccp_pin_model.sv
// tccp_pin_model: external sources and pull-up loads on the channel pins
module tccp_pin_model (
  // timer side
  input wire logic [1:0] oe_i,
  input wire logic [1:0] lvl_i,
  // external source
  input wire logic [1:0] drv_en_i,
  input wire logic [1:0] drv_lvl_i,
  // resolved wire
  output logic [1:0] pin_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // an undriven pin floats up, never holds its last value
  always_comb begin
    for (int k = 0; k < 2; k++) begin
      pin_o[k] = oe_i[k] ? lvl_i[k] : (drv_en_i[k] ? drv_lvl_i[k] : 1'b1);
    end
  end
endmodule

// file: dv/tb.sv
// tb: self-checking bench for the timer block
module tb
  import tccp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst_n, psel, penable, pwrite, pready, pslverr, ovf_irq;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [1:0] pin_in, pin_o, pin_oe, ch_irq, drv_en, drv_lvl;
  int num_errors = 0;
  int n_compared = 0;
  tccp_top dut_u (
    .clk_i(clk),
    .reset_n_i(rst_n),
    .paddr_i(paddr),
    .psel_i(psel),
    .penable_i(penable),
    .pwrite_i(pwrite),
    .pwdata_i(pwdata),
    .pstrb_i(4'hF),
    .prdata_o(prdata),
    .pready_o(pready),
    .pslverr_o(pslverr),
    .ch_pin_i(pin_in),
    .ch_pin_o(pin_o),
    .ch_pin_oe_o(pin_oe),
    .ovf_irq_o(ovf_irq),
    .ch_irq_o(ch_irq)
  );
  tccp_pin_model pm_u (
    .oe_i(pin_oe),
    .lvl_i(pin_o),
    .drv_en_i(drv_en),
    .drv_lvl_i(drv_lvl),
    .pin_o(pin_in)
  );
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // ==========
  // bus and compare helpers
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    #1;
    n_compared++;
    if (g !== x) begin
      num_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, g, x);
    end
  endtask
  // request holds until ready is seen high at an edge; answer taken there
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d,
                     output logic [31:0] r, output logic e);
    int n = 0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      num_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, pready, 1'b1);
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask
  task automatic rdv(input logic [7:0] a, output logic [31:0] r);
    logic e;
    apb(1'b0, a, 8'h00, r, e);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    logic [31:0] r;
    rdv(a, r);
    chk(r, x);
  endtask
  // flag clear needs the arming read first
  task automatic clr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] r;
    rdv(a, r);
    wr(a, d);
  endtask
  // ==========
  // scenarios
  task automatic t_reset();
    logic [31:0] r;
    logic e;
    chk(32'({pin_oe, ch_irq, ovf_irq}), 32'h0);
    rd(OFF_MAIN, 32'h20);
    rd(OFF_LIM_HI, 32'hFF);
    rd(OFF_LIM_LO, 32'hFF);
    rd(OFF_CH0_CTL, 32'h0);
    rd(OFF_CNT_HI, 32'h0);
    rd(OFF_CNT_LO, 32'h0);
    apb(1'b0, 8'h2C, 8'h00, r, e);
    chk({r[30:0], e}, 32'h1);
  endtask
  task automatic t_counter();
    logic [31:0] r, lo1, lo2;
    wr(OFF_MAIN, 8'h00);
    repeat (100) @(posedge clk);
    rdv(OFF_CNT_HI, r);
    wr(OFF_MAIN, 8'h20);
    rdv(OFF_CNT_LO, lo1);
    rdv(OFF_CNT_LO, lo2);
    chk(32'(lo2 > lo1), 32'h1);
    wr(OFF_MAIN, 8'h30);
    rd(OFF_CNT_LO, 32'h0);
    wr(OFF_MAIN, 8'h06);
    repeat (640) @(posedge clk);
    wr(OFF_MAIN, 8'h26);
    rdv(OFF_CNT_LO, r);
    chk(32'(r inside {[9:11]}), 32'h1);
  endtask
  task automatic t_ovf();
    logic [31:0] r;
    wr(OFF_LIM_HI, 8'h00);
    wr(OFF_LIM_LO, 8'h20);
    wr(OFF_MAIN, 8'h40);
    for (int i = 0; i < 100 && ovf_irq !== 1'b1; i++) @(posedge clk);
    chk(32'(ovf_irq), 32'h1);
    rd(OFF_MAIN, 32'hC0);
    wr(OFF_MAIN, 8'h60);
    repeat (3) @(posedge clk);
    chk(32'(ovf_irq), 32'h0);
    rdv(OFF_CNT_LO, r);
    chk(32'(r <= 32'h20), 32'h1);
    wr(OFF_LIM_HI, 8'h00);
    wr(OFF_MAIN, 8'h40);
    repeat (100) @(posedge clk);
    chk(32'(ovf_irq), 32'h0);
    wr(OFF_LIM_LO, 8'h20);
    for (int i = 0; i < 100 && ovf_irq !== 1'b1; i++) @(posedge clk);
    chk(32'(ovf_irq), 32'h1);
    clr(OFF_MAIN, 8'h30);
  endtask
  // set starts from a low preset, toggle and clear from a high one
  task automatic t_compare();
    logic [7:0] ctl;
    logic [31:0] x;
    for (int c = 1; c < 4; c++) begin
      ctl = 8'h50 | 8'(c << 2);
      wr(OFF_MAIN, 8'h30);
      wr(OFF_CH0_CTL, (c == 3) ? 8'h10 : 8'h00);
      repeat (3) @(posedge clk);
      chk(32'({pin_oe[0], pin_o[0]}), (c == 3) ? 32'h0 : 32'h1);
      wr(OFF_CH0_HI, 8'h00);
      wr(OFF_CH0_LO, 8'h10);
      wr(OFF_CH0_CTL, ctl);
      wr(OFF_MAIN, 8'h00);
      for (int i = 0; i < 100 && ch_irq[0] !== 1'b1; i++) @(posedge clk);
      repeat (2) @(posedge clk);
      x = (c == 3) ? 32'h7 : 32'h6;
      chk(32'({ch_irq[0], pin_oe[0], pin_o[0]}), x);
      clr(OFF_CH0_CTL, ctl);
      repeat (3) @(posedge clk);
      chk(32'(ch_irq[0]), 32'h0);
    end
    rd(OFF_CH0_LO, 32'h10);
  endtask
  task automatic t_capture();
    logic [7:0] ctl;
    logic [31:0] r;
    wr(OFF_MAIN, 8'h00);
    for (int c = 1; c < 4; c++) begin
      ctl = 8'h40 | 8'(c << 2);
      wr(OFF_CH1_CTL, ctl);
      repeat (8) @(posedge clk);
      drv_lvl[1] <= 1'b1;
      repeat (10) @(posedge clk);
      chk(32'(ch_irq[1]), 32'(c & 1));
      clr(OFF_CH1_CTL, ctl);
      drv_lvl[1] <= 1'b0;
      repeat (10) @(posedge clk);
      chk(32'(ch_irq[1]), 32'(c >> 1));
      clr(OFF_CH1_CTL, ctl);
    end
    // an upper value read holds off captures until the lower read
    wr(OFF_CH1_CTL, 8'h44);
    rdv(OFF_CH1_HI, r);
    drv_lvl[1] <= 1'b1;
    repeat (10) @(posedge clk);
    chk(32'(ch_irq[1]), 32'h0);
    rdv(OFF_CH1_LO, r);
    drv_lvl[1] <= 1'b0;
  endtask
  task automatic t_link();
    wr(OFF_MAIN, 8'h30);
    wr(OFF_CH1_CTL, 8'h14);
    repeat (3) @(posedge clk);
    chk(32'(pin_oe[1]), 32'h1);
    wr(OFF_CH0_CTL, 8'h24);
    repeat (3) @(posedge clk);
    chk(32'(pin_oe[1]), 32'h0);
    wr(OFF_CH1_CTL, 8'h00);
    rd(OFF_CH1_CTL, 32'h14);
  endtask
  // buffered pwm, period 33: high from wrap to match, then full duty
  task automatic t_pwm();
    int hi;
    wr(OFF_MAIN, 8'h30);
    wr(OFF_CH0_HI, 8'h00);
    wr(OFF_CH0_LO, 8'h08);
    wr(OFF_CH0_CTL, 8'h2A);
    wr(OFF_MAIN, 8'h00);
    for (int k = 0; k < 2; k++) begin
      repeat (70) @(posedge clk);
      hi = 0;
      repeat (33) begin
        @(posedge clk);
        hi += pin_o[0];
      end
      chk(32'(hi), (k == 0) ? 32'h8 : 32'h21);
      wr(OFF_CH0_CTL, 8'h2B);
    end
  endtask
  // ==========
  // verdict and run control
  task automatic report_and_stop();
    $display("errors %0d compared %0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    #1200000;
    num_errors++;
    report_and_stop();
  end
  initial begin
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    drv_en = 2'h3;
    drv_lvl = 2'h0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_counter();
    t_ovf();
    t_compare();
    t_capture();
    t_link();
    t_pwm();
    report_and_stop();
  end
endmodule
